// *** cod_core.sv ***
/*
 * Opcode decoder core: fetches bytes from program memory, times each
 * instruction in four-clock instruction cycles, executes arithmetic,
 * logic, rotate, accumulator moves, absolute and relative jumps, and
 * halts on the breakpoint opcode. Control over classic Wishbone.
 * Assumes program memory on the same clock, returning the byte one
 * cycle after its address is presented.
 */
// The implementer's own choices: the address map and the Wishbone register port.
// Function
// [RL1] Opcode a5 is a breakpoint that halts the core and flags it.
// [RL2] Each instruction cycle lasts exactly four clock cycles.
// [RL3] Absolute jump or call replaces low 11 bits of following address.
// [RL4] Direct address below 80 is RAM, from 80 upward special registers.
// [RL5] Indirect operand uses the pointer held in R0 or R1.
// [RL6] Short and conditional jumps add a signed offset byte.
// [RL7] Instruction length equals bytes fetched and consumed.
// [RL8] Only the marked flags change; others keep their value.
// [RL9] Sum into accumulator: 28-2f, 25, 26-27, 24; four flags.
// [RL10] Sum with carry: 38-3f, 35, 36-37, 34; four flags.
// [RL11] Difference with borrow: 98-9f, 95, 96-97, 94; four flags.
// [RL12] And: 58-5f, 55, 56-57, 54 into accumulator; 52, 53 direct.
// [RL13] Or: 48-4f, 45, 46-47, 44 into accumulator; 42, 43 direct.
// [RL14] Exclusive or: 68-6f, 65, 66-67, 64; 62, 63 direct.
// [RL15] Rotates 23, 03 no flags; 33, 13 carry; swap c4 none.
// [RL16] Copy into accumulator from register e8-ef or direct e5.
// [RL17] Parity flag is one when accumulator has odd count of ones.
// [RL18] Carry set on add carry or subtract borrow, used by rotates.
// [RL19] Low three opcode bits pick register; lowest bit picks R0/R1.
// [RL20] Operand bytes follow the opcode; counter advances past them.
`timescale 1ns/1ps
`default_nettype none
module cod_core
   import cod_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // Wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   // Program memory read port
   output logic [15:0] FLASH_ADDR,
   output logic FLASH_RD,
   input wire logic [7:0] FLASH_DATA,
   // Status
   output logic BREAK_HIT
);
   logic [3:0] cnt;
   logic running;
   logic brk_hit;
   logic [15:0] pc;
   logic [15:0] fa;
   logic [7:0] opcode;
   logic [7:0] op1;
   logic [7:0] op2;
   logic [7:0] acc;
   logic [7:0] b_reg;
   logic [7:0] sp;
   logic [7:0] psw_st;
   logic [7:0] psw_rd;
   logic [7:0] ram [256];
   cod_class_t cls;
   cod_src_t src;
   cod_dst_t dst;
   logic [1:0] len;
   logic [1:0] cycles;
   logic [2:0] fmask;
   logic last;
   logic push_lo;
   logic [7:0] reg_addr;
   logic [7:0] ind_addr;
   logic [7:0] sfr_val;
   logic [7:0] dir_val;
   logic [7:0] src_val;
   logic [7:0] a_in;
   logic [7:0] res;
   logic alu_cy;
   logic alu_ac;
   logic alu_ov;
   logic [15:0] seq_pc;
   logic [15:0] next_pc;
   logic dir_ram_wr;
   logic [8:0] add9;
   logic ack;
   logic bus_req;
   logic bus_wr;
   logic [7:0] bus_off;

   // Decoder and ALU
   cod_decode u_dec (
      .opcode(opcode),
      .cls(cls),
      .src(src),
      .dst(dst),
      .len(len),
      .cycles(cycles),
      .fmask(fmask)
   );

   cod_alu u_alu (
      .cls(cls),
      .a(a_in),
      .b(src_val),
      .cy_in(psw_st[PSW_CY]),
      .res(res),
      .cy(alu_cy),
      .ac(alu_ac),
      .ov(alu_ov)
   );

   // Commit falls on the last clock of the last instruction cycle
   assign last = running && (cnt == {cycles - 2'd1, 2'b11}); // [RL2]
   assign push_lo = running && (cls == C_ACALL) && (cnt == 4'ha);

   // Sequencer: counter is idle at zero while halted
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         cnt <= 4'h0;
      end else if (!running || last) begin
         cnt <= 4'h0;
      end else begin
         cnt <= cnt + 4'h1; // [RL2]
      end
   end

   // Byte fetch: address tracks the counter, byte lands next clock
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         fa <= 16'h0000;
      end else if (!running) begin
         fa <= pc;
      end else if (last) begin
         fa <= next_pc;
      end else if (cnt < 4'h3) begin
         fa <= pc + {14'h0000, cnt[1:0]} + 16'h0001; // [RL20]
      end
   end

   assign FLASH_ADDR = fa;
   assign FLASH_RD = running;

   // Capture of opcode and operand bytes in fetch order
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         opcode <= 8'h00;
         op1 <= 8'h00;
         op2 <= 8'h00;
      end else if (running) begin
         if (cnt == 4'h1) begin
            opcode <= FLASH_DATA;
         end
         if (cnt == 4'h2) begin
            op1 <= FLASH_DATA; // [RL20]
         end
         if (cnt == 4'h3) begin
            op2 <= FLASH_DATA; // [RL20]
         end
      end
   end

   // Operand addressing inside the selected bank
   assign reg_addr = {3'b000, psw_st[4:3], opcode[2:0]}; // [RL19]
   assign ind_addr = ram[{3'b000, psw_st[4:3], 2'b00, opcode[0]}]; // [RL5] [RL19]
   assign psw_rd = {psw_st[7:1], ^acc}; // [RL17]

   // Direct space: low half RAM, high half special registers
   always_comb begin
      case (op1)
         SFR_ACC: sfr_val = acc;
         SFR_PSW: sfr_val = psw_rd;
         SFR_B: sfr_val = b_reg;
         SFR_SP: sfr_val = sp;
         default: sfr_val = 8'h00;
      endcase
   end

   assign dir_val = (op1 >= SFR_BASE) ? sfr_val : ram[op1]; // [RL4]

   // Source operand select
   always_comb begin
      case (src)
         S_REG: src_val = ram[reg_addr];
         S_DIR: src_val = dir_val;
         S_IND: src_val = ram[ind_addr]; // [RL5]
         S_IMM: src_val = op1;
         S_IMM2: src_val = op2;
         default: src_val = acc;
      endcase
   end

   assign a_in = (dst == D_DIR) ? dir_val : acc;
   assign add9 = {1'b0, acc} + {1'b0, src_val};

   // Next program counter
   always_comb begin
      seq_pc = pc + {14'h0000, len}; // [RL7] [RL20]
      next_pc = seq_pc;
      case (cls)
         C_AJMP, C_ACALL: next_pc = {seq_pc[15:11], opcode[7:5], op1}; // [RL3]
         C_SHORT_JUMP: next_pc = seq_pc + {{8{op1[7]}}, op1}; // [RL6]
         C_JC: begin
            if (psw_st[PSW_CY]) begin
               next_pc = seq_pc + {{8{op1[7]}}, op1}; // [RL6]
            end
         end
         default: next_pc = seq_pc;
      endcase
   end

   // Program counter: software may load it only while halted
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         pc <= 16'h0000;
      end else if (last) begin
         pc <= next_pc;
      end else if (!running && bus_wr && bus_off == REG_PC) begin
         if (WB_SEL_I[0]) begin
            pc[7:0] <= WB_DAT_I[7:0];
         end
         if (WB_SEL_I[1]) begin
            pc[15:8] <= WB_DAT_I[15:8];
         end
      end
   end

   // Accumulator and B
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         acc <= 8'h00;
         b_reg <= 8'h00;
      end else if (last) begin
         if (dst == D_ACC || (dst == D_DIR && op1 == SFR_ACC)) begin
            acc <= res;
         end
         if (dst == D_DIR && op1 == SFR_B) begin
            b_reg <= res;
         end
      end
   end

   // Status word: a direct write to PSW loads it whole, else only masked flags move
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         psw_st <= 8'h00;
      end else if (last) begin
         if (dst == D_DIR && op1 == SFR_PSW) begin
            psw_st <= res;
         end else begin
            if (fmask[FM_CY]) begin
               psw_st[PSW_CY] <= alu_cy; // [RL8] [RL18]
            end
            if (fmask[FM_AC]) begin
               psw_st[PSW_AC] <= alu_ac; // [RL8]
            end
            if (fmask[FM_OV]) begin
               psw_st[PSW_OV] <= alu_ov; // [RL8]
            end
         end
      end
   end

   // Stack pointer: call pushes two bytes
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         sp <= SP_RST;
      end else if (last && cls == C_ACALL) begin
         sp <= sp + 8'h02;
      end else if (last && dst == D_DIR && op1 == SFR_SP) begin
         sp <= res;
      end
   end

   // Internal RAM: one write a clock; low return byte goes first
   assign dir_ram_wr = last && dst == D_DIR && op1 < SFR_BASE; // [RL4]

   always_ff @(posedge CLK) begin
      if (push_lo) begin
         ram[sp + 8'h01] <= seq_pc[7:0];
      end else if (last && cls == C_ACALL) begin
         ram[sp + 8'h02] <= seq_pc[15:8];
      end else if (dir_ram_wr) begin
         ram[op1] <= res;
      end
   end

   // Bus request decode; a write lands on the edge where the master sees ack
   assign bus_req = WB_CYC_I && WB_STB_I && !ack;
   assign bus_wr = WB_CYC_I && WB_STB_I && ack && WB_WE_I;
   assign bus_off = {WB_ADR_I[7:2], 2'b00};

   // Run control: breakpoint wins over a run write in the same clock
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         running <= 1'b0;
      end else if (last && cls == C_BRK) begin
         running <= 1'b0; // [RL1]
      end else if (bus_wr && bus_off == REG_CTRL && WB_SEL_I[0]) begin
         running <= WB_DAT_I[CTRL_RUN];
      end
   end

   // Sticky breakpoint flag; a new hit beats a clear
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         brk_hit <= 1'b0;
      end else if (last && cls == C_BRK) begin
         brk_hit <= 1'b1; // [RL1]
      end else if (bus_wr && bus_off == REG_STATUS && WB_SEL_I[0] && WB_DAT_I[STAT_BRK]) begin
         brk_hit <= 1'b0;
      end
   end

   assign BREAK_HIT = brk_hit;

   // Acknowledge one clock after the request; read data in the same edge
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ack <= 1'b0;
         WB_DAT_O <= 32'h00000000;
      end else begin
         ack <= bus_req;
         if (bus_req && !WB_WE_I) begin
            case (bus_off)
               REG_CTRL: WB_DAT_O <= {31'h00000000, running};
               REG_STATUS: WB_DAT_O <= {30'h00000000, brk_hit, running};
               REG_PC: WB_DAT_O <= {16'h0000, pc};
               REG_CORE: WB_DAT_O <= {sp, b_reg, psw_rd, acc};
               default: WB_DAT_O <= 32'h00000000;
            endcase
         end
      end
   end

   assign WB_ACK_O = ack;

   // Commit lands on the fourth clock of its last instruction cycle
   a_icycle_four: assert property (@(posedge CLK) disable iff (!RST_N)
      last |-> (cnt[1:0] == 2'b11 && cnt[3:2] == cycles - 2'd1)) // [RL2]
      else $error("commit off the instruction cycle grid");

   // Breakpoint halts, flags and steps past itself
   a_break_halt: assert property (@(posedge CLK) disable iff (!RST_N)
      (last && cls == C_BRK) |=> (!running && brk_hit && pc == $past(pc) + 16'h0001)) // [RL1]
      else $error("breakpoint did not halt the core");

   // Absolute target keeps the block of the following byte
   a_abs_target: assert property (@(posedge CLK) disable iff (!RST_N)
      (last && cls == C_AJMP) |=>
      pc == {$past(seq_pc[15:11]), $past(opcode[7:5]), $past(op1)}) // [RL3]
      else $error("absolute jump target wrong");

   // Relative jump adds the signed offset
   a_rel_jump: assert property (@(posedge CLK) disable iff (!RST_N)
      (last && cls == C_SHORT_JUMP) |=>
      pc == $past(seq_pc) + {{8{$past(op1[7])}}, $past(op1)}) // [RL6]
      else $error("short jump target wrong");

   // Plain instructions advance by their length
   a_seq_advance: assert property (@(posedge CLK) disable iff (!RST_N)
      (last && !(cls inside {C_AJMP, C_ACALL, C_SHORT_JUMP, C_JC})) |=>
      pc == $past(pc) + {14'h0000, $past(len)}) // [RL7]
      else $error("program counter did not advance by length");

   // The second operand byte address follows the first
   a_fetch_next: assert property (@(posedge CLK) disable iff (!RST_N)
      (running && cnt == 4'h1) |-> ##1 (!running || fa == pc + 16'h0002)) // [RL20]
      else $error("operand fetch address wrong");

   // Carry untouched when not marked
   a_flag_keep: assert property (@(posedge CLK) disable iff (!RST_N)
      (last && !fmask[FM_CY] && !(dst == D_DIR && op1 == SFR_PSW)) |=>
      $stable(psw_st[PSW_CY])) // [RL8]
      else $error("unmarked carry changed");

   // Carry from a plain sum
   a_add_carry: assert property (@(posedge CLK) disable iff (!RST_N)
      (last && cls == C_ADD) |=> psw_st[PSW_CY] == $past(add9[8])) // [RL18]
      else $error("sum carry wrong");

   // Direct write below the special range lands in RAM
   a_direct_ram: assert property (@(posedge CLK) disable iff (!RST_N)
      dir_ram_wr |=> ram[$past(op1)] == $past(res)) // [RL4]
      else $error("direct RAM write lost");

   // One acknowledge per request
   a_bus_ack: assert property (@(posedge CLK) disable iff (!RST_N)
      bus_req |=> ack ##1 !ack)
      else $error("bus acknowledge not a single pulse");
endmodule : cod_core
`default_nettype wire

// *** cod_pkg.sv ***
/*
 * Shared constants and types for the opcode decoder core: opcodes,
 * status word fields, special function addresses, bus offsets.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package cod_pkg;
   // Clock and instruction timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int ICYC_CLKS = 4;
   // Opcodes handled one by one
   localparam logic [7:0] OP_BRK = 8'ha5;
   localparam logic [7:0] OP_SHORT_JUMP = 8'h80;
   localparam logic [7:0] OP_JC = 8'h40;
   localparam logic [7:0] OP_RL = 8'h23;
   localparam logic [7:0] OP_RR = 8'h03;
   localparam logic [7:0] OP_RLC = 8'h33;
   localparam logic [7:0] OP_RRC = 8'h13;
   localparam logic [7:0] OP_SWAP = 8'hc4;
   localparam logic [7:0] OP_MOV_DIR = 8'he5;
   // Opcode groups by high nibble, forms by low nibble, absolute jump and call by low five bits
   localparam logic [3:0] HI_ADD = 4'h2;
   localparam logic [3:0] HI_SUM_WITH_CARRY_IN = 4'h3;
   localparam logic [3:0] HI_DIFFERENCE_WITH_BORROW = 4'h9;
   localparam logic [3:0] HI_OR = 4'h4;
   localparam logic [3:0] HI_AND = 4'h5;
   localparam logic [3:0] HI_XOR = 4'h6;
   localparam logic [3:0] HI_MOV = 4'he;
   localparam logic [3:0] LO_IMM = 4'h4;
   localparam logic [3:0] LO_DIR = 4'h5;
   localparam logic [3:0] LO_DIR_A = 4'h2;
   localparam logic [3:0] LO_DIR_IMM = 4'h3;
   localparam logic [4:0] ABS_JMP = 5'h01;
   localparam logic [4:0] ABS_CALL = 5'h11;
   // Status word bit positions and flag mask positions
   localparam int PSW_CY = 7;
   localparam int PSW_AC = 6;
   localparam int PSW_OV = 2;
   localparam int PSW_P = 0;
   localparam int FM_CY = 2;
   localparam int FM_AC = 1;
   localparam int FM_OV = 0;
   // Special function addresses and reset values
   localparam logic [7:0] SFR_BASE = 8'h80;
   localparam logic [7:0] SFR_ACC = 8'he0;
   localparam logic [7:0] SFR_PSW = 8'hd0;
   localparam logic [7:0] SFR_B = 8'hf0;
   localparam logic [7:0] SFR_SP = 8'h81;
   localparam logic [7:0] SP_RST = 8'h07;
   // Bus register offsets and bit positions
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_PC = 8'h08;
   localparam logic [7:0] REG_CORE = 8'h0c;
   localparam int CTRL_RUN = 0;
   localparam int STAT_RUN = 0;
   localparam int STAT_BRK = 1;
   // Four-state bases, so a decoded field may travel on a wire port
   typedef enum logic [4:0] {C_NOP, C_ADD, C_SUM_WITH_CARRY_IN, C_DIFFERENCE_WITH_BORROW, C_AND, C_OR, C_XOR, C_MOV,
                             C_RL, C_RR, C_RLC, C_RRC, C_SWAP, C_AJMP, C_ACALL, C_SHORT_JUMP,
                             C_JC, C_BRK} cod_class_t;
   typedef enum logic [2:0] {S_ACC, S_REG, S_DIR, S_IND, S_IMM, S_IMM2} cod_src_t;
   typedef enum logic [1:0] {D_NONE, D_ACC, D_DIR} cod_dst_t;
endpackage : cod_pkg
`default_nettype wire

// *** cod_alu.sv ***
/*
 * Byte ALU: sums, differences with borrow, logic, rotates, nibble swap.
 * Assumes the caller picks which result flags it keeps.
 */
`timescale 1ns/1ps
`default_nettype none
module cod_alu
   import cod_pkg::*;
(
   // Operation and operands
   input wire cod_class_t cls,
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic cy_in,
   // Result and flags
   output logic [7:0] res,
   output logic cy,
   output logic ac,
   output logic ov
);
   logic cin;
   logic [8:0] wide;
   logic [4:0] nib;

   // Carry in only for the carry-using forms
   assign cin = (cls == C_ADD) ? 1'b0 : cy_in;

   // One combinational result path per class
   always_comb begin
      wide = 9'h000;
      nib = 5'h00;
      res = b;
      cy = cy_in;
      ac = 1'b0;
      ov = 1'b0;
      case (cls)
         C_ADD, C_SUM_WITH_CARRY_IN: begin
            wide = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            res = wide[7:0];
            cy = wide[8];
            ac = nib[4];
            ov = (a[7] == b[7]) && (wide[7] != a[7]);
         end
         C_DIFFERENCE_WITH_BORROW: begin
            wide = {1'b0, a} - {1'b0, b} - {8'h00, cy_in};
            nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cy_in};
            res = wide[7:0];
            cy = wide[8]; // Borrow
            ac = nib[4];
            ov = (a[7] != b[7]) && (wide[7] != a[7]);
         end
         C_AND: res = a & b;
         C_OR: res = a | b;
         C_XOR: res = a ^ b;
         C_RL: res = {a[6:0], a[7]};
         C_RR: res = {a[0], a[7:1]};
         C_RLC: begin
            res = {a[6:0], cy_in};
            cy = a[7];
         end
         C_RRC: begin
            res = {cy_in, a[7:1]};
            cy = a[0];
         end
         C_SWAP: res = {a[3:0], a[7:4]};
         default: res = b;
      endcase
   end
endmodule : cod_alu
`default_nettype wire

// *** cod_decode.sv ***
/*
 * Opcode decoder: class, operand form, target, length, timing, flags.
 * Assumes the opcode register is stable while its outputs are used.
 */
`timescale 1ns/1ps
`default_nettype none
module cod_decode
   import cod_pkg::*;
(
   // Opcode in
   input wire logic [7:0] opcode,
   // Decoded fields
   output cod_class_t cls,
   output cod_src_t src,
   output cod_dst_t dst,
   output logic [1:0] len,
   output logic [1:0] cycles,
   output logic [2:0] fmask
);
   logic [3:0] hi;
   logic [3:0] lo;
   logic logic_grp;

   assign hi = opcode[7:4];
   assign lo = opcode[3:0];
   assign logic_grp = (hi == HI_AND) || (hi == HI_OR) || (hi == HI_XOR);

   // Specials first, then the regular group layout
   always_comb begin
      cls = C_NOP;
      src = S_ACC;
      dst = D_NONE;
      len = 2'd1;
      cycles = 2'd1;
      fmask = 3'b000;
      if (opcode == OP_BRK) begin
         cls = C_BRK; // [RL1]
      end else if (opcode == OP_SHORT_JUMP || opcode == OP_JC) begin
         cls = (opcode == OP_SHORT_JUMP) ? C_SHORT_JUMP : C_JC; // [RL6]
         len = 2'd2;
         cycles = 2'd3;
      end else if (opcode == OP_RL || opcode == OP_RR || opcode == OP_SWAP) begin
         cls = (opcode == OP_RL) ? C_RL : (opcode == OP_RR) ? C_RR : C_SWAP; // [RL15]
         dst = D_ACC;
      end else if (opcode == OP_RLC || opcode == OP_RRC) begin
         cls = (opcode == OP_RLC) ? C_RLC : C_RRC; // [RL15]
         dst = D_ACC;
         fmask = 3'b100;
      end else if (opcode[4:0] == ABS_JMP || opcode[4:0] == ABS_CALL) begin
         cls = (opcode[4:0] == ABS_JMP) ? C_AJMP : C_ACALL; // [RL3]
         len = 2'd2;
         cycles = 2'd3;
      end else if (hi == HI_ADD || hi == HI_SUM_WITH_CARRY_IN || hi == HI_DIFFERENCE_WITH_BORROW || logic_grp ||
                   (hi == HI_MOV && (lo[3] || lo == LO_DIR))) begin
         case (hi)
            HI_ADD: cls = C_ADD; // [RL9]
            HI_SUM_WITH_CARRY_IN: cls = C_SUM_WITH_CARRY_IN; // [RL10]
            HI_DIFFERENCE_WITH_BORROW: cls = C_DIFFERENCE_WITH_BORROW; // [RL11]
            HI_AND: cls = C_AND; // [RL12]
            HI_OR: cls = C_OR; // [RL13]
            HI_XOR: cls = C_XOR; // [RL14]
            default: cls = C_MOV; // [RL16]
         endcase
         fmask = logic_grp || hi == HI_MOV ? 3'b000 : 3'b111; // [RL8]
         dst = D_ACC;
         if (lo[3]) begin
            src = S_REG; // [RL19]
         end else if (lo[3:1] == 3'b011) begin
            src = S_IND; // [RL19]
         end else if (lo == LO_DIR || lo == LO_IMM) begin
            src = (lo == LO_DIR) ? S_DIR : S_IMM;
            len = 2'd2;
            cycles = 2'd2;
         end else if (logic_grp && lo == LO_DIR_A) begin
            dst = D_DIR;
            len = 2'd2;
            cycles = (hi == HI_XOR) ? 2'd3 : 2'd2; // [RL14]
         end else if (logic_grp && lo == LO_DIR_IMM) begin
            src = S_IMM2;
            dst = D_DIR;
            len = 2'd3;
            cycles = 2'd3;
         end else begin
            cls = C_NOP;
            dst = D_NONE;
            fmask = 3'b000;
         end
      end
   end
endmodule : cod_decode
`default_nettype wire

// *** cod_flash_model.sv ***
/*
 * Program memory model: 256 bytes, read one cycle after the address.
 * Assumes the core clock and a bench that fills mem while the core halts.
 */
`timescale 1ns/1ps
`default_nettype none
module cod_flash_model (
   // Clock
   input wire logic clk,
   // Read port
   input wire logic [15:0] addr,
   input wire logic rd,
   output logic [7:0] data
);
   logic [7:0] mem [0:255];
   logic [7:0] last;

   // Byte of the previous cycle's address; the inverted last byte once reads stop
   always_ff @(posedge clk) begin
      if (rd) begin
         data <= mem[addr[7:0]];
         last <= mem[addr[7:0]];
      end else begin
         data <= ~last; // Not the last byte, so stale reads show up
      end
   end
endmodule : cod_flash_model
`default_nettype wire

// *** cod_core_test.sv ***
/*
 * Self-checking bench for the decoder core: random instruction runs
 * from the memory model, results and timing compared with a model.
 * Assumes the core package and the program memory model.
 */
`timescale 1ns/1ps
`default_nettype none
module cod_core_test;
   import cod_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0;
   logic [31:0] q;
   logic [31:0] rdat;
   logic [31:0] e;
   logic ack, rd, hit;
   logic [15:0] fa;
   logic [7:0] fd;
   int error_cnt = 0;
   int checks_done = 0;
   int m_acc = 0, m_cy = 0, m_ac = 0, m_ov = 0, m_b = 0;
   int ops [17] = '{8'h24, 8'h34, 8'h94, 8'h54, 8'h44, 8'h64, 8'h33, 8'h13, 8'h23,
                    8'h03, 8'hc4, 8'he5, 8'h43, 8'h63, 8'h80, 8'h01, 8'h40};
   int lens [17] = '{2, 2, 2, 2, 2, 2, 1, 1, 1, 1, 1, 2, 3, 3, 3, 3, 3};
   int prog [16] = '{8'h53, 8'h00, 8'h00, 8'h43, 8'h00, 8'h10, 8'h53, 8'h10, 8'h00, 8'h43,
                     8'h10, 8'h00, 8'he8, 8'h26, 8'he5, 8'h10};

   cod_core u_dut (.CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(rdat),
      .WB_ACK_O(ack), .FLASH_ADDR(fa), .FLASH_RD(rd), .FLASH_DATA(fd), .BREAK_HIT(hit));
   cod_flash_model u_mem (.clk(clk), .addr(fa), .rd(rd), .data(fd));

   // Clock
   initial begin
      forever #5 clk = ~clk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk

   // Classic single cycle; hold until ack is sampled, then release
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (n >= 50) chk(32'h0, 32'h1);
   endtask : wb

   // Reference behaviour of one instruction on accumulator, flags and B
   task automatic model(input int op, input int k);
      int r, c;
      c = (op == 8'h34 || op == 8'h94) ? m_cy : 0;
      r = m_acc;
      case (op)
         8'h24, 8'h34: begin
            r = m_acc + k + c;
            m_ac = ((m_acc & 15) + (k & 15) + c) > 15;
            m_ov = ((m_acc ^ r) & (k ^ r) & 8'h80) != 0;
            m_cy = r > 255;
         end
         8'h94: begin
            r = m_acc - k - c;
            m_ac = (m_acc & 15) < (k & 15) + c;
            m_ov = ((m_acc ^ k) & (m_acc ^ r) & 8'h80) != 0;
            m_cy = r < 0;
         end
         8'h54: r = m_acc & k;
         8'h44: r = m_acc | k;
         8'h64: r = m_acc ^ k;
         8'h33: begin
            r = (m_acc << 1) | m_cy;
            m_cy = m_acc >> 7;
         end
         8'h13: begin
            r = (m_acc >> 1) | (m_cy << 7);
            m_cy = m_acc & 1;
         end
         8'h23: r = (m_acc << 1) | (m_acc >> 7);
         8'h03: r = (m_acc >> 1) | (m_acc << 7);
         8'hc4: r = (m_acc << 4) | (m_acc >> 4);
         8'he5: r = m_b;
         8'h43: m_b = m_b | k;
         8'h63: m_b = m_b ^ k;
         default: r = m_acc;
      endcase
      m_acc = r & 255;
   endtask : model

   function automatic logic [31:0] core_exp();
      logic [7:0] a;
      a = m_acc[7:0];
      return {8'h07, m_b[7:0], m_cy[0], m_ac[0], 3'b000, m_ov[0], 1'b0, ^a, a};
   endfunction : core_exp

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude

   // Watchdog at 10000 cycles, far beyond the under one thousand the runs need
   initial begin
      #100000;
      error_cnt++;
      conclude();
   end

   // Main sequence: nine programs, each ending on the breakpoint
   initial begin
      int pc, ncyc, cnt, n, idx, op, k;
      n = $urandom(32'h436f);
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      for (int t = 0; t < 9; t++) begin
         for (int i = 0; i < 256; i++) u_mem.mem[i] = OP_BRK;
         pc = 0;
         ncyc = 1;
         // Last round: RAM, register and pointer forms; R0 points at 10, which holds k
         if (t == 8) begin
            k = $urandom % 256;
            for (int i = 0; i < 16; i++) u_mem.mem[i] = prog[i][7:0];
            u_mem.mem[11] = k[7:0];
            m_acc = 8'h10;
            model(8'h24, k);
            m_acc = k;
            ncyc = 17;
         end
         // First rounds walk every opcode, later ones pick at random
         for (int i = 0; i < 6 && t < 8; i++) begin
            idx = (t < 3) ? (t * 6 + i) % 17 : $urandom % 17;
            op = ops[idx];
            k = (op == 8'he5) ? 8'hf0 : $urandom % 256;
            u_mem.mem[pc] = op[7:0];
            if (lens[idx] == 3) u_mem.mem[pc + 1] = SFR_B;
            if (lens[idx] > 1) u_mem.mem[pc + lens[idx] - 1] = k[7:0];
            // Jumps skip one byte: a trap, or for JC a no-op run when not taken
            if (lens[idx] == 3 && op != 8'h43 && op != 8'h63) begin
               u_mem.mem[pc + 1] = (op == 8'h01) ? 8'(pc + 3) : 8'h01;
               u_mem.mem[pc + 2] = (op == OP_JC) ? 8'h00 : OP_BRK;
               ncyc += (op == OP_JC && m_cy == 0);
            end
            pc += lens[idx];
            ncyc += lens[idx];
            model(op, k);
         end
         wb(1'b1, REG_PC, 32'h0);
         wb(1'b1, REG_STATUS, 32'h2);
         wb(1'b1, REG_CTRL, 32'h1);
         cnt = 0; // Run starts on the acknowledge edge
         n = 0;
         do begin
            @(posedge clk);
            cnt += (rd === 1'b1);
            n++;
         end while (hit !== 1'b1 && n < 2000);
         chk(cnt, 4 * ncyc);
         wb(1'b0, REG_CORE, 32'h0);
         e = core_exp();
         chk(q & 32'hff, e & 32'hff);
         chk(q & ~32'hff, e & ~32'hff);
         wb(1'b0, REG_STATUS, 32'h0);
         chk(q, 32'h2);
         $display("round %0d done", t);
      end
      wb(1'b0, 8'h10, 32'h0);
      chk(q, 32'h0);
      $display("unmapped read done");
      conclude();
   end
endmodule : cod_core_test
`default_nettype wire
